// file: sgr_checker.sv
`timescale 1ns/1ps
module sgr_checker
	import sgr_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [7:0] op,
	input wire logic op_stb,
	input wire logic [7:0] ans,
	input wire logic ans_vld,
	input wire logic [3:0] delay_units,
	input wire logic gate_open
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// ****************************************
	// pod link answers
	// ****************************************
	property p_rd_ans; op_stb && op == OP_READ |=> ans_vld; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read got no answer");
	property p_ans_cause; ans_vld |-> $past(op_stb && op == OP_READ); endproperty
	a_ans_cause: assert property (p_ans_cause) else $error("answer without read");
	property p_ans_pulse; ans_vld |=> !ans_vld; endproperty
	a_ans_pulse: assert property (p_ans_pulse) else $error("answer valid too long");
	property p_ans_hold; !ans_vld |-> $stable(ans); endproperty
	a_ans_hold: assert property (p_ans_hold) else $error("answer changed without read");
	// ****************************************
	// gate and delay
	// ****************************************
	property p_rd_keep; op_stb && op == OP_READ && gate_open |=> gate_open; endproperty
	a_rd_keep: assert property (p_rd_keep) else $error("read closed the gate");
	property p_disarm; op_stb && op == OP_DISARM |-> ##[1:2] !gate_open; endproperty
	a_disarm: assert property (p_disarm) else $error("disarm left gate open");
	property p_rst_gate; op_stb && op == OP_RST_GATE |-> ##[1:2] !gate_open; endproperty
	a_rst_gate: assert property (p_rst_gate) else $error("gate reset left gate open");
	property p_dly_max; op_stb && op == (OP_DLY | 8'h0f) |-> ##[1:2] delay_units == 4'hc; endproperty
	a_dly_max: assert property (p_dly_max) else $error("delay code max wrong");
	property p_dly_unused; op_stb && op == (OP_DLY | 8'h03) |=> $stable(delay_units) [*2]; endproperty
	a_dly_unused: assert property (p_dly_unused) else $error("unused delay code taken");
endmodule // sgr_checker

// file: sgr_dev.sv
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module sgr_dev
	import sgr_pkg::*;
#(
	parameter int ACT_CYC = CLK_ACT_CYC
) (
	input wire logic core_clk,
	input wire logic reset_n,
	sgr_pod_if.dev pod,
	input wire logic ext_start,
	input wire logic ext_stop,
	input wire logic ext_clk,
	input wire logic ext_enable,
	input wire logic probe_data,
	input wire logic pod_sync,
	input wire logic gnd_ok,
	output logic [3:0] delay_units,
	output logic gate_open
);
	localparam int ACT_W = $clog2(ACT_CYC + 1);
	if (ACT_CYC < 1) begin : g_chk
		$error("activity window must be at least one cycle");
	end
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		sgr_gate_e gate;
		logic start_seen;
		logic stop_seen;
		logic start_fall;
		logic start_sync;
		logic stop_fall;
		logic stop_start;
		logic clk_both;
		logic clk_fall;
		logic clk_sync;
		logic en_held;
		logic en_low;
		logic ev_free;
		logic ev_clks;
		logic run_ev_clks;
		logic [11:0] cnt_cfg;
		logic [11:0] cnt_lim;
		logic [11:0] cnt_run;
		logic [3:0] dly;
		logic [6:0] prev;
		logic [ACT_W-1:0] act;
		logic [0:CHAIN_DEPTH-1][3:0] chain;
		logic [7:0] ans;
		logic ans_vld;
		logic is_open;
	} sgr_dev_s;
	sgr_dev_s q, d;
	logic [6:0] sy;
	sgr_sync #(.W(7)) u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.async_in({gnd_ok, pod_sync, probe_data, ext_enable, ext_clk, ext_stop, ext_start}),
		.sync_out(sy)
	);
	function automatic logic [3:0] dly_map(input logic [3:0] c);
		dly_map = c - {2'b00, c[3:2]};
	endfunction
	function automatic logic sel_edge(input logic fall, input logic r, input logic f);
		sel_edge = fall ? f : r;
	endfunction
	// ****************************************
	// next state
	// ****************************************
	logic [6:0] rise, fall;
	logic start_ev, stop_ev, clk_ev, en_ok, data_tr, qclk, ev_src, ev_hit;
	logic [15:0] sig;
	logic [23:0] evc;
	logic [63:0] wave;
	always_comb begin
		d = q;
		d.ans_vld = 1'b0;
		d.prev = sy;
		rise = sy & ~q.prev;
		fall = ~sy & q.prev;
		start_ev = q.start_sync ? sel_edge(q.start_fall, rise[5], fall[5])
			: sel_edge(q.start_fall, rise[0], fall[0]);
		stop_ev = q.stop_start ? sel_edge(q.stop_fall, rise[0], fall[0])
			: sel_edge(q.stop_fall, rise[1], fall[1]);
		clk_ev = q.clk_sync ? (q.clk_both ? rise[5] | fall[5] : sel_edge(q.clk_fall, rise[5], fall[5]))
			: (q.clk_both ? rise[2] | fall[2] : sel_edge(q.clk_fall, rise[2], fall[2]));
		en_ok = q.en_held | (sy[3] ^ q.en_low);
		data_tr = rise[4] | fall[4];
		qclk = (q.gate == G_OPEN) & en_ok & clk_ev;
		ev_src = q.run_ev_clks ? clk_ev : data_tr;
		ev_hit = q.ev_free ? ev_src & (q.gate != G_IDLE)
			: ev_src & en_ok & (q.gate == G_OPEN);
		sig = q.chain[SIG_POS +: SIG_NIBS];
		evc = q.chain[EV_POS +: EV_NIBS];
		wave = q.chain[WAVE_POS +: WAVE_NIBS];
		// clock activity window
		if (clk_ev) begin
			d.act = ACT_W'(ACT_CYC);
		end else if (q.act != '0) begin
			d.act = q.act - ACT_W'(1);
		end
		// acquisition
		if (qclk) begin
			sig = {sig[14:0], sy[4] ^ sig[15] ^ sig[11] ^ sig[8] ^ sig[6]};
			wave = {wave[61:0], sy[4], ~sy[4]};
			d.cnt_run = q.cnt_run + 12'h1;
			if (q.cnt_lim != '0 && q.cnt_run + 12'h1 == q.cnt_lim) begin
				d.gate = G_DONE;
			end
		end
		if (ev_hit) begin
			evc = evc + 24'h1;
		end
		d.chain[SIG_POS +: SIG_NIBS] = sig;
		d.chain[EV_POS +: EV_NIBS] = evc;
		d.chain[WAVE_POS +: WAVE_NIBS] = wave;
		if (q.gate == G_ARMED && start_ev) begin
			d.gate = G_OPEN;
			d.start_seen = 1'b1;
		end
		if (q.gate == G_OPEN && stop_ev) begin
			d.gate = G_DONE;
			d.stop_seen = 1'b1;
		end
		// ****************************************
		// opcodes
		// ****************************************
		if (pod.op_stb) begin
			if (pod.op == OP_DISARM) begin
				if (q.gate != G_DONE) begin
					d.gate = G_IDLE;
				end
			end else if (pod.op == OP_RST_GATE || pod.op == OP_RST_ALL) begin
				d.gate = G_IDLE;
				d.start_seen = 1'b0;
				d.stop_seen = 1'b0;
				d.cnt_run = '0;
				if (pod.op == OP_RST_ALL) begin
					d.chain = '0;
				end
			end else if (pod.op == OP_ARM) begin
				d.chain = '0;
				d.start_seen = 1'b0;
				d.stop_seen = 1'b0;
				d.cnt_run = '0;
				d.cnt_lim = q.cnt_cfg;
				d.run_ev_clks = q.ev_clks;
				d.gate = G_ARMED;
			end else if (pod.op == OP_SHIFT) begin
				d.chain = {q.chain[1:CHAIN_DEPTH-1], 4'h0};
			end else if (pod.op == OP_READ) begin
				d.ans = {sy[6], q.stop_seen, q.start_seen, q.act != '0, q.chain[0]};
				d.ans_vld = 1'b1;
			end else if (pod.op[7:2] == OP_START[7:2]) begin
				{d.start_sync, d.start_fall} = pod.op[1:0];
			end else if (pod.op[7:2] == OP_STOP[7:2]) begin
				{d.stop_start, d.stop_fall} = pod.op[1:0];
			end else if (pod.op[7:3] == OP_CLK[7:3]) begin
				{d.clk_sync, d.clk_fall, d.clk_both} = pod.op[2:0];
			end else if (pod.op[7:2] == OP_EN[7:2]) begin
				{d.en_low, d.en_held} = pod.op[1:0];
			end else if (pod.op[7:2] == OP_EV[7:2]) begin
				{d.ev_clks, d.ev_free} = pod.op[1:0];
			end else if (pod.op[7:4] == OP_DLY[7:4]) begin
				if (pod.op[1:0] != 2'b11 || pod.op[3:2] == 2'b11) begin
					d.dly = dly_map(pod.op[3:0]);
				end
			end else if (pod.op[7:4] == OP_CNT0[7:4]) begin
				d.cnt_cfg[3:0] = pod.op[3:0];
			end else if (pod.op[7:4] == OP_CNT1[7:4]) begin
				d.cnt_cfg[7:4] = pod.op[3:0];
			end else if (pod.op[7:4] == OP_CNT2[7:4]) begin
				d.cnt_cfg[11:8] = pod.op[3:0];
			end
		end
		d.is_open = (d.gate == G_OPEN);
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign pod.ans = q.ans;
	assign pod.ans_vld = q.ans_vld;
	assign delay_units = q.dly;
	assign gate_open = q.is_open;
endmodule // sgr_dev

// file: sgr_host.sv
`timescale 1ns/1ps
module sgr_host
	import sgr_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	sgr_pod_if.host pod,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	typedef struct packed {
		sgr_hst_e st;
		sgr_cmd_e kind;
		logic [5:0] idx;
		logic [31:0] setup;
		logic [7:0] raw;
		logic [31:0] res_a;
		logic [31:0] res_b;
		logic [7:0] op;
		logic op_stb;
		logic [31:0] rdata;
	} sgr_host_s;
	sgr_host_s q, d;
	// ****************************************
	// opcode sequences
	// ****************************************
	function automatic logic [5:0] seq_len(input sgr_cmd_e k);
		case (k)
			C_SETUP: seq_len = 6'd11;
			C_ARM: seq_len = 6'd7;
			C_SIG: seq_len = 6'(2 + 2 * SIG_NIBS);
			C_EV: seq_len = 6'(2 + 2 * EV_NIBS);
			C_WAVE: seq_len = 6'(2 + 2 * WAVE_NIBS);
			default: seq_len = 6'd1;
		endcase
	endfunction
	function automatic logic [7:0] cnt_op(input logic [1:0] n, input logic [31:0] su);
		case (n)
			2'd0: cnt_op = OP_CNT0 | {4'h0, su[SU_CNT_LSB +: 4]};
			2'd1: cnt_op = OP_CNT1 | {4'h0, su[SU_CNT_LSB + 4 +: 4]};
			default: cnt_op = OP_CNT2 | {4'h0, su[SU_CNT_LSB + 8 +: 4]};
		endcase
	endfunction
	function automatic logic [7:0] seq_op(input sgr_cmd_e k, input logic [5:0] i,
			input logic [31:0] su, input logic [7:0] raw);
		logic [7:0] evop;
		evop = OP_EV | {6'h0, su[SU_EV_CLKS], su[SU_EV_FREE]};
		seq_op = OP_READ;
		if (k == C_RAW) begin
			seq_op = raw;
		end else if (k != C_STAT && i == 6'd0) begin
			seq_op = OP_DISARM;
		end else if (k == C_ARM) begin
			case (i)
				6'd1: seq_op = OP_RST_ALL;
				6'd2: seq_op = cnt_op(2'd0, su);
				6'd3: seq_op = cnt_op(2'd1, su);
				6'd4: seq_op = cnt_op(2'd2, su);
				6'd5: seq_op = evop;
				default: seq_op = OP_ARM;
			endcase
		end else if (k == C_SETUP) begin
			case (i)
				6'd1: seq_op = OP_RST_GATE;
				6'd2: seq_op = OP_START | {6'h0, su[SU_START_SYNC], su[SU_START_FALL]};
				6'd3: seq_op = OP_STOP | {6'h0, su[SU_STOP_START], su[SU_STOP_FALL]};
				6'd4: seq_op = OP_CLK | {5'h0, su[SU_CLK_SYNC], su[SU_CLK_FALL], su[SU_CLK_BOTH]};
				6'd5: seq_op = OP_EN | {6'h0, su[SU_EN_LOW], su[SU_EN_HELD]};
				6'd6: seq_op = cnt_op(2'd0, su);
				6'd7: seq_op = cnt_op(2'd1, su);
				6'd8: seq_op = cnt_op(2'd2, su);
				6'd9: seq_op = OP_DLY | {4'h0, su[SU_DLY_LSB +: 4]};
				default: seq_op = evop;
			endcase
		end else if (k != C_STAT) begin
			if (i == 6'd1) begin
				seq_op = OP_RST_GATE;
			end else if (i[0]) begin
				seq_op = OP_SHIFT;
			end
		end
	endfunction
	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d = q;
		d.op_stb = 1'b0;
		d.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				HR_SETUP: d.rdata = q.setup;
				HR_RAW: d.rdata = {24'h0, q.raw};
				HR_STAT: d.rdata = {31'h0, q.st != H_IDLE};
				HR_RES_A: d.rdata = q.res_a;
				HR_RES_B: d.rdata = q.res_b;
				default: d.rdata = '0;
			endcase
		end
		if (reg_wr && reg_addr == HR_SETUP) begin
			d.setup = reg_wdata;
		end
		if (reg_wr && reg_addr == HR_RAW) begin
			d.raw = reg_wdata[7:0];
		end
		case (q.st)
			H_IDLE: begin
				if (reg_wr && reg_addr == HR_CMD && sgr_cmd_e'(reg_wdata[2:0]) != C_NONE) begin
					d.kind = sgr_cmd_e'(reg_wdata[2:0]);
					d.idx = '0;
					d.st = H_SEND;
				end
			end
			H_SEND: begin
				d.op = seq_op(q.kind, q.idx, q.setup, q.raw);
				d.op_stb = 1'b1;
				if (d.op == OP_READ) begin
					d.st = H_WAIT;
				end else if (q.idx + 6'd1 == seq_len(q.kind)) begin
					d.st = H_IDLE;
				end else begin
					d.idx = q.idx + 6'd1;
				end
			end
			H_WAIT: begin
				if (pod.ans_vld) begin
					case (q.kind)
						C_SIG: d.res_b = {q.res_b[27:0], pod.ans[3:0]};
						C_EV: d.res_a = {q.res_a[27:0], pod.ans[3:0]};
						C_WAVE: begin
							d.res_a = {q.res_a[29:0], pod.ans[3:2]};
							d.res_b = {q.res_b[29:0], pod.ans[1:0]};
						end
						default: d.res_b = {24'h0, pod.ans};
					endcase
					d.idx = q.idx + 6'd1;
					d.st = (q.idx + 6'd1 == seq_len(q.kind)) ? H_IDLE : H_SEND;
				end
			end
			default: d.st = H_IDLE;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign pod.op = q.op;
	assign pod.op_stb = q.op_stb;
	assign reg_rdata = q.rdata;
endmodule // sgr_host

// file: sgr_pkg.sv
package sgr_pkg;
	// ****************************************
	// setup word fields
	// ****************************************
	localparam int SU_START_FALL = 3;
	localparam int SU_START_SYNC = 4;
	localparam int SU_STOP_FALL = 5;
	localparam int SU_STOP_START = 6;
	localparam int SU_CLK_BOTH = 7;
	localparam int SU_CLK_FALL = 8;
	localparam int SU_CLK_SYNC = 9;
	localparam int SU_EN_HELD = 10;
	localparam int SU_EN_LOW = 11;
	localparam int SU_CNT_LSB = 12;
	localparam int SU_DLY_LSB = 24;
	localparam int SU_EV_FREE = 28;
	localparam int SU_EV_CLKS = 29;
	localparam int DLY_UNIT_NS = 3;
	// ****************************************
	// opcodes
	// ****************************************
	localparam logic [7:0] OP_DISARM = 8'h01;
	localparam logic [7:0] OP_RST_GATE = 8'h02;
	localparam logic [7:0] OP_RST_ALL = 8'h03;
	localparam logic [7:0] OP_ARM = 8'h04;
	localparam logic [7:0] OP_SHIFT = 8'h05;
	localparam logic [7:0] OP_START = 8'h10;
	localparam logic [7:0] OP_STOP = 8'h14;
	localparam logic [7:0] OP_CLK = 8'h18;
	localparam logic [7:0] OP_EN = 8'h20;
	localparam logic [7:0] OP_EV = 8'h24;
	localparam logic [7:0] OP_DLY = 8'h30;
	localparam logic [7:0] OP_CNT0 = 8'h40;
	localparam logic [7:0] OP_CNT1 = 8'h50;
	localparam logic [7:0] OP_CNT2 = 8'h60;
	localparam logic [7:0] OP_READ = 8'h80;
	// ****************************************
	// shift chain and status
	// ****************************************
	localparam int CHAIN_DEPTH = 26;
	localparam int SIG_POS = 0;
	localparam int SIG_NIBS = 4;
	localparam int EV_POS = 4;
	localparam int EV_NIBS = 6;
	localparam int WAVE_POS = 10;
	localparam int WAVE_NIBS = 16;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_ACT_MS = 200;
	localparam int CLK_ACT_CYC = CLK_ACT_MS * (1000000 / CLK_PERIOD_NS);
	// ****************************************
	// host registers and commands
	// ****************************************
	localparam logic [7:0] HR_SETUP = 8'h00;
	localparam logic [7:0] HR_CMD = 8'h04;
	localparam logic [7:0] HR_RAW = 8'h08;
	localparam logic [7:0] HR_STAT = 8'h0c;
	localparam logic [7:0] HR_RES_A = 8'h10;
	localparam logic [7:0] HR_RES_B = 8'h14;
	typedef enum logic [2:0] {
		C_SETUP = 3'b000, C_ARM = 3'b001, C_SIG = 3'b010, C_EV = 3'b011,
		C_WAVE = 3'b100, C_STAT = 3'b101, C_RAW = 3'b110, C_NONE = 3'b111
	} sgr_cmd_e;
	typedef enum logic [1:0] {
		G_IDLE = 2'b00, G_ARMED = 2'b01, G_OPEN = 2'b10, G_DONE = 2'b11
	} sgr_gate_e;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00, H_SEND = 2'b01, H_WAIT = 2'b10
	} sgr_hst_e;
endpackage

// file: sgr_pod_if.sv
`timescale 1ns/1ps
interface sgr_pod_if;
	logic [7:0] op;
	logic op_stb;
	logic [7:0] ans;
	logic ans_vld;
	modport dev (input op, input op_stb, output ans, output ans_vld);
	modport host (output op, output op_stb, input ans, input ans_vld);
endinterface

// file: sgr_sync.sv
`timescale 1ns/1ps
module sgr_sync #(
	parameter int W = 7
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sgr_sync_s;
	sgr_sync_s q, d;
	always_comb begin
		d.s1 = async_in;
		d.s2 = q.s1;
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign sync_out = q.s2;
endmodule // sgr_sync

// file: signature_gate_setup_readout_tb.sv
`timescale 1ns/1ps
module signature_gate_setup_readout_tb
	import sgr_pkg::*;
();
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic st = 1'b0, sp = 1'b0, ck = 1'b0, en = 1'b0, pd = 1'b0, sy = 1'b0, gnd = 1'b1;
	logic [3:0] delay_units;
	logic gate_open;
	logic [31:0] r;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	sgr_pod_if pod ();
	sgr_dev #(.ACT_CYC(50)) u_sgr_dev (.core_clk(core_clk), .reset_n(reset_n), .pod(pod),
		.ext_start(st), .ext_stop(sp), .ext_clk(ck), .ext_enable(en), .probe_data(pd),
		.pod_sync(sy), .gnd_ok(gnd), .delay_units(delay_units), .gate_open(gate_open));
	sgr_host u_sgr_host (.core_clk(core_clk), .reset_n(reset_n), .pod(pod), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	sgr_checker u_sgr_checker (.core_clk(core_clk), .reset_n(reset_n), .op(pod.op),
		.op_stb(pod.op_stb), .ans(pod.ans), .ans_vld(pod.ans_vld),
		.delay_units(delay_units), .gate_open(gate_open));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count = err_count + 1;
			results();
		end
	end
	// ****************************************
	// helpers
	// ****************************************
	task results();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			err_count = err_count + 1;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task gap(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task cmd(input logic [2:0] c);
		logic [31:0] s;
		int i;
		wr(HR_CMD, {29'h0, c});
		for (i = 0; i < 2000; i++) begin
			rd(HR_STAT, s);
			if (s[0] === 1'b0) break;
		end
		if (i == 2000) chk(32'h0, 32'h1, "command hang");
	endtask
	task run(input logic [31:0] su);
		wr(HR_SETUP, su);
		cmd(3'd0);
		cmd(3'd1);
	endtask
	task clks(input int n, input logic d);
		repeat (n) begin
			@(posedge core_clk);
			ck <= 1'b1;
			pd <= d;
			gap(3);
			ck <= 1'b0;
			gap(2);
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_delay();
		logic [3:0] e;
		int i;
		e = 4'h0;
		for (i = 0; i < 16; i++) begin
			wr(HR_SETUP, {4'h0, 4'(i), 24'h0});
			cmd(3'd0);
			if (i % 4 != 3 || i == 15) e = 4'(i - i / 4);
			chk({28'h0, delay_units}, {28'h0, e}, "delay units");
		end
	endtask
	task t_acq();
		logic [15:0] s;
		s = 16'h0;
		run(32'h2000_0400);
		gap(4);
		chk({31'h0, gate_open}, 32'h0, "gate open before start");
		st <= 1'b1;
		gap(6);
		chk({31'h0, gate_open}, 32'h1, "gate closed after start");
		st <= 1'b0;
		clks(32, 1'b1);
		repeat (32) s = {s[14:0], 1'b1 ^ s[15] ^ s[11] ^ s[8] ^ s[6]};
		sp <= 1'b1;
		gap(6);
		chk({31'h0, gate_open}, 32'h0, "gate open after stop");
		sp <= 1'b0;
		cmd(3'd5);
		rd(HR_RES_B, r);
		chk({28'h0, r[7:4]}, 32'hf, "status flags");
		chk({28'h0, r[3:0]}, {28'h0, s[15:12]}, "status nibble");
		cmd(3'd2);
		rd(HR_RES_B, r);
		chk({16'h0, r[15:0]}, {16'h0, s}, "signature");
		cmd(3'd3);
		rd(HR_RES_A, r);
		chk({8'h0, r[23:0]}, 32'd32, "event count");
		cmd(3'd4);
		rd(HR_RES_A, r);
		chk(r, 32'haaaa_aaaa, "wave high");
		rd(HR_RES_B, r);
		chk(r, 32'haaaa_aaaa, "wave low");
		cmd(3'd2);
		rd(HR_RES_B, r);
		chk({16'h0, r[15:0]}, 32'h0, "chain not emptied");
	endtask
	task t_count();
		en <= 1'b1;
		run(32'h2000_5000);
		st <= 1'b1;
		gap(6);
		st <= 1'b0;
		clks(7, 1'b0);
		chk({31'h0, gate_open}, 32'h0, "gate open past count");
		cmd(3'd2);
		cmd(3'd3);
		rd(HR_RES_A, r);
		chk({8'h0, r[23:0]}, 32'd5, "counted pulses");
	endtask
	task t_disarm();
		run(32'h0000_0008);
		st <= 1'b1;
		gap(6);
		chk({31'h0, gate_open}, 32'h0, "opened on rising");
		st <= 1'b0;
		gap(6);
		chk({31'h0, gate_open}, 32'h1, "not opened on falling");
		clks(2, 1'b1);
		cmd(3'd5);
		chk({31'h0, gate_open}, 32'h1, "status read closed gate");
		rd(HR_RES_B, r);
		chk({24'h0, r[7:0]}, 32'hb0, "status while open");
		wr(HR_RAW, {24'h0, OP_DISARM});
		cmd(3'd6);
		chk({31'h0, gate_open}, 32'h0, "disarm left gate open");
		gnd <= 1'b0;
		gap(60);
		cmd(3'd5);
		rd(HR_RES_B, r);
		chk({24'h0, r[7:0]}, 32'h20, "status after idle");
		gnd <= 1'b1;
		cmd(3'd2);
		rd(HR_RES_B, r);
		chk({16'h0, r[15:0]}, 32'h3, "disarm lost chain");
		rd(8'h20, r);
		chk(r, 32'h0, "unmapped read");
	endtask
	task t_modes();
		logic [15:0] s;
		s = 16'h0;
		en <= 1'b0;
		run(32'h1000_08d0);
		st <= 1'b1;
		gap(6);
		chk({31'h0, gate_open}, 32'h0, "opened from start pin");
		st <= 1'b0;
		sy <= 1'b1;
		gap(6);
		chk({31'h0, gate_open}, 32'h1, "not opened from sync");
		sy <= 1'b0;
		clks(1, 1'b0);
		clks(1, 1'b1);
		repeat (2) s = {s[14:0], s[15] ^ s[11] ^ s[8] ^ s[6]};
		repeat (2) s = {s[14:0], 1'b1 ^ s[15] ^ s[11] ^ s[8] ^ s[6]};
		st <= 1'b1;
		gap(6);
		chk({31'h0, gate_open}, 32'h0, "stop from start pin missed");
		st <= 1'b0;
		pd <= 1'b0;
		gap(6);
		cmd(3'd2);
		rd(HR_RES_B, r);
		chk({16'h0, r[15:0]}, {16'h0, s}, "signature both edges");
		cmd(3'd3);
		rd(HR_RES_A, r);
		chk({8'h0, r[23:0]}, 32'd3, "free-run transitions");
	endtask
	initial begin
		gap(8);
		reset_n <= 1'b1;
		gap(2);
		t_delay();
		t_acq();
		t_count();
		t_disarm();
		t_modes();
		results();
	end
endmodule // signature_gate_setup_readout_tb
